// ### common/osc_map.svh
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// Register offsets
`define OSC_STAT_ADDR 8'h0E
`define OSC_CTRL_ADDR 8'h0F

// Reset value of the control register: configuration, clock out on, divide by 8
`define OSC_CTRL_RST 8'h87

// Field positions
`define OSC_MODE_MSB 7
`define OSC_MODE_LSB 5
`define OSC_ABAT_BIT 4
`define OSC_OSM_BIT 3
`define OSC_CLOCK_OUTPUT_ENABLE_BIT 2
`define OSC_PRE_MSB 1
`define OSC_PRE_LSB 0
`define OSC_ICOD_MSB 3
`define OSC_ICOD_LSB 1

// Mode codes
`define OSC_MODE_NORMAL 3'h0
`define OSC_MODE_SLEEP 3'h1
`define OSC_MODE_LOOP 3'h2
`define OSC_MODE_LISTEN 3'h3
`define OSC_MODE_CONFIG 3'h4

// Timing: one oscillator cycle spans two system clocks
`define OSC_CLK_PER_OSC 2
`define OSC_OST_OSC_CYCLES 128
`define OSC_OST_CYCLES (`OSC_OST_OSC_CYCLES * `OSC_CLK_PER_OSC)
`define OSC_DRAIN_PERIODS 16

`endif

// ### common/osc_pkg.sv
package osc_pkg;

  typedef enum logic [1:0] {
    OSC_ST_STARTUP,
    OSC_ST_RUN,
    OSC_ST_DRAIN,
    OSC_ST_SLEEP
  } osc_state_e;

  typedef struct packed {
    logic [2:0] req;
    logic abat;
    logic osm;
    logic clock_output_enable;
    logic [1:0] pre;
  } osc_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } osc_bus_req_s;

  typedef struct packed {
    osc_state_e state;
    osc_ctrl_s ctrl;
    logic [2:0] cur;
    logic [8:0] oscillator_startup_timer;
    logic [4:0] drain;
    logic [7:0] rdata;
    logic core_reset;
    logic osc_stop;
  } osc_main_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] sel;
    logic out;
    logic act;
    logic oe_n;
  } osc_div_s;

  // Half period of the clock output minus one, in system clocks
  function automatic logic [2:0] osc_half_m1(input logic [1:0] sel);
    case (sel)
      2'h0: osc_half_m1 = 3'h0;
      2'h1: osc_half_m1 = 3'h1;
      2'h2: osc_half_m1 = 3'h3;
      default: osc_half_m1 = 3'h7;
    endcase
  endfunction : osc_half_m1

endpackage : osc_pkg

// ### rtl/osc_clk_div.sv
`timescale 1ns/10ps

module osc_clk_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic clk_o,
  output logic oe_n,
  output logic bnd
);
  import osc_pkg::*;

  osc_div_s s_ff;
  osc_div_s nxt_s;
  logic [2:0] hm1;

  assign hm1 = osc_half_m1(s_ff.sel);
  // Period boundary: end of a low phase, or idle
  assign bnd = !s_ff.act || (!s_ff.out && s_ff.cnt == hm1);

  always_comb begin
    nxt_s = s_ff;
    if (bnd) begin
      nxt_s.cnt = 3'h0;
      nxt_s.sel = sel;
      nxt_s.oe_n = ~en;
      nxt_s.act = en & run;
      nxt_s.out = en & run;
    end else if (s_ff.cnt == hm1) begin
      nxt_s.cnt = 3'h0;
      nxt_s.out = ~s_ff.out;
    end else begin
      nxt_s.cnt = s_ff.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '{cnt: 3'h0, sel: 2'h3, out: 1'b0, act: 1'b0, oe_n: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign clk_o = s_ff.out;
  assign oe_n = s_ff.oe_n;

  logic [3:0] ph_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_ff <= 4'h1;
    end else if (nxt_s.out != s_ff.out) begin
      ph_ff <= 4'h1;
    end else if (ph_ff != 4'hF) begin
      ph_ff <= ph_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  phase_width_a: assert property ((s_ff.act && nxt_s.act && nxt_s.out != s_ff.out) |->
    ph_ff == ({1'b0, hm1} + 4'h1))
    else $error("clock out phase has wrong width");
  sel_boundary_a: assert property ($changed(s_ff.sel) |-> !$past(s_ff.out))
    else $error("divider changed inside a high phase");
  oe_safe_a: assert property ($changed(oe_n) |-> !$past(s_ff.out))
    else $error("clock out enable changed inside a high phase");

  div_change_c: cover property ($changed(s_ff.sel) && s_ff.act);

endmodule : osc_clk_div

// ### rtl/osc_pin_sync.sv
`timescale 1ns/10ps

module osc_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  import osc_pkg::*;

  if (WIDTH < 1) begin : g_width_chk
    $error("osc_pin_sync WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } osc_sync_s;

  osc_sync_s s_ff;
  osc_sync_s nxt_s;

  // Level follows only once the second and third stages agree
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = pin_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.lvl = (~(s_ff.s2 ^ s_ff.s3) & s_ff.s2) | ((s_ff.s2 ^ s_ff.s3) & s_ff.lvl);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level_o = s_ff.lvl;

endmodule : osc_pin_sync

// ### rtl/osc_startup_clock_output_pin_mode_ctrl.sv
`timescale 1ns/10ps
`include "osc_map.svh"

// Contract
// - Hold core reset 128 oscillator cycles after any reset or wake.
// - Clock output is oscillator divided by 1, 2, 4 or 8.
// - After any reset clock output runs at divide by eight.
// - Sixteen more clock output cycles before sleep and oscillator stop.
// - In sleep with clock output enabled, pin is held low.
// - Enable bit zero releases the clock output pin.
// - Enable, disable and ratio change never shorten a phase.
// - Reset pin low, once synchronised and filtered, and serial reset command have the same effect.
// - Five modes chosen by three-bit request field, control bits 7 to 5.
// - Mode switch waits until pending transmissions finish.
// - Request codes 000 normal to 100 configuration; others invalid.
// - Status bits 7 to 5 show mode in force, same codes.
// - Divider field 00..11 selects 1,2,4,8; enable at control bit 2.
module osc_startup_clock_output_pin_mode_ctrl #(
  parameter int unsigned OST_CYCLES = `OSC_OST_CYCLES,
  parameter int unsigned DRAIN_PERIODS = `OSC_DRAIN_PERIODS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_PIN_N,
  input wire logic SPI_RESET_CMD,
  input wire osc_pkg::osc_bus_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic TX_PENDING,
  input wire logic WAKE_EVENT,
  input wire logic [2:0] INT_CODE,
  output logic CORE_RESET,
  output logic OSC_STOP,
  output logic [2:0] OP_MODE,
  output logic ABORT_ALL,
  output logic ONE_SHOT,
  output logic CLOCK_OUTPUT_PIN_O,
  output logic CLOCK_OUTPUT_PIN_OE_N
);
  import osc_pkg::*;

  if (OST_CYCLES < 2 || OST_CYCLES > 512) begin : g_ost_chk
    $error("OST_CYCLES must lie in 2..512");
  end
  if (DRAIN_PERIODS < 1 || DRAIN_PERIODS > 31) begin : g_drain_chk
    $error("DRAIN_PERIODS must lie in 1..31");
  end

  localparam logic [8:0] OST_LAST = 9'(OST_CYCLES - 1);
  localparam logic [4:0] DRAIN_LAST = 5'(DRAIN_PERIODS);
  localparam osc_ctrl_s CTRL_RST = `OSC_CTRL_RST;
  localparam osc_main_s MAIN_RST = '{
    state: OSC_ST_STARTUP,
    ctrl: CTRL_RST,
    cur: `OSC_MODE_CONFIG,
    oscillator_startup_timer: 9'h000,
    drain: 5'h00,
    rdata: 8'h00,
    core_reset: 1'b1,
    osc_stop: 1'b0
  };

  osc_main_s st_ff;
  osc_main_s nxt_st;
  logic pin_rst_n;
  logic rst_evt;
  logic bus_ok;
  logic req_valid;
  logic [2:0] req;
  logic div_bnd;
  logic div_run;

  osc_pin_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_rst_sync (
    .clk(CLK),
    .rst(RST),
    .pin_i(RESET_PIN_N),
    .level_o(pin_rst_n)
  );

  // Both reset sources feed one path
  assign rst_evt = ~pin_rst_n | SPI_RESET_CMD;
  assign req = st_ff.ctrl.req;
  assign req_valid = (req <= `OSC_MODE_CONFIG);
  // Bus is dead while the start-up timer runs
  assign bus_ok = (st_ff.state != OSC_ST_STARTUP);
  // Stop the divider at the boundary closing the last drain period
  assign div_run = (st_ff.state != OSC_ST_SLEEP) &&
    !(st_ff.state == OSC_ST_DRAIN && div_bnd && st_ff.drain == DRAIN_LAST);

  osc_clk_div u_clk_div (
    .clk(CLK),
    .rst(RST),
    .en(st_ff.ctrl.clock_output_enable),
    .run(div_run),
    .sel(st_ff.ctrl.pre),
    .clk_o(CLOCK_OUTPUT_PIN_O),
    .oe_n(CLOCK_OUTPUT_PIN_OE_N),
    .bnd(div_bnd)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    // Register read, data one cycle later
    if (bus_ok && REG_REQ.rd) begin
      case (REG_REQ.addr)
        `OSC_CTRL_ADDR: begin
          nxt_st.rdata = st_ff.ctrl;
        end
        `OSC_STAT_ADDR: begin
          nxt_st.rdata[`OSC_MODE_MSB:`OSC_MODE_LSB] = st_ff.cur;
          nxt_st.rdata[`OSC_ICOD_MSB:`OSC_ICOD_LSB] = INT_CODE;
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end
    // Control write; status is read only
    if (bus_ok && REG_REQ.wr && REG_REQ.addr == `OSC_CTRL_ADDR) begin
      nxt_st.ctrl = REG_REQ.wdata;
    end
    case (st_ff.state)
      OSC_ST_STARTUP: begin
        if (st_ff.oscillator_startup_timer == OST_LAST) begin
          nxt_st.state = OSC_ST_RUN;
          nxt_st.core_reset = 1'b0;
        end else begin
          nxt_st.oscillator_startup_timer = st_ff.oscillator_startup_timer + 9'h001;
        end
      end
      OSC_ST_RUN: begin
        // Switch only when no transmission is pending
        if (req_valid && req != st_ff.cur && !TX_PENDING) begin
          if (req == `OSC_MODE_SLEEP) begin
            nxt_st.state = OSC_ST_DRAIN;
            nxt_st.drain = 5'h00;
          end else begin
            nxt_st.cur = req;
          end
        end
      end
      OSC_ST_DRAIN: begin
        if (req != `OSC_MODE_SLEEP) begin
          nxt_st.state = OSC_ST_RUN;
        end else if (div_bnd) begin
          if (st_ff.drain == DRAIN_LAST) begin
            nxt_st.state = OSC_ST_SLEEP;
            nxt_st.cur = `OSC_MODE_SLEEP;
            nxt_st.osc_stop = 1'b1;
          end else begin
            nxt_st.drain = st_ff.drain + 5'h01;
          end
        end
      end
      OSC_ST_SLEEP: begin
        // Wake restarts the timer and lands in listen-only
        if (WAKE_EVENT) begin
          nxt_st.state = OSC_ST_STARTUP;
          nxt_st.oscillator_startup_timer = 9'h000;
          nxt_st.core_reset = 1'b1;
          nxt_st.osc_stop = 1'b0;
          nxt_st.cur = `OSC_MODE_LISTEN;
          nxt_st.ctrl.req = `OSC_MODE_LISTEN;
        end
      end
      default: begin
        nxt_st = MAIN_RST;
      end
    endcase
    // Any reset source restores defaults and restarts the count
    if (rst_evt) begin
      nxt_st = MAIN_RST;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= MAIN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA = st_ff.rdata;
  assign CORE_RESET = st_ff.core_reset;
  assign OSC_STOP = st_ff.osc_stop;
  assign OP_MODE = st_ff.cur;
  assign ABORT_ALL = st_ff.ctrl.abat;
  assign ONE_SHOT = st_ff.ctrl.osm;

  // Checking aids
  logic [9:0] since_ff;
  logic [4:0] rise_ff;
  logic prev_clk_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      since_ff <= 10'h000;
      rise_ff <= 5'h00;
      prev_clk_ff <= 1'b0;
    end else begin
      prev_clk_ff <= CLOCK_OUTPUT_PIN_O;
      if (rst_evt || (st_ff.state == OSC_ST_SLEEP && WAKE_EVENT)) begin
        since_ff <= 10'h000;
      end else if (since_ff != 10'h3FF) begin
        since_ff <= since_ff + 10'h001;
      end
      if (st_ff.state != OSC_ST_DRAIN) begin
        rise_ff <= 5'h00;
      end else if (CLOCK_OUTPUT_PIN_O && !prev_clk_ff && rise_ff != 5'h1F) begin
        rise_ff <= rise_ff + 5'h01;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ost_length_a: assert property ($fell(CORE_RESET) |-> since_ff == 10'(OST_CYCLES))
    else $error("start-up hold has wrong length");
  reset_default_a: assert property (rst_evt |=>
    (CORE_RESET && OP_MODE == `OSC_MODE_CONFIG && st_ff.ctrl == CTRL_RST))
    else $error("reset source did not restore defaults");
  ost_ignore_a: assert property ((CORE_RESET && REG_REQ.wr && !rst_evt) |=>
    $stable(st_ff.ctrl))
    else $error("write taken during start-up");
  ost_read_a: assert property ((CORE_RESET && REG_REQ.rd) |=> REG_RDATA == 8'h00)
    else $error("read answered during start-up");
  mode_defer_a: assert property ((st_ff.state == OSC_ST_RUN && TX_PENDING && !rst_evt) |=>
    $stable(OP_MODE))
    else $error("mode changed with transmission pending");
  mode_switch_a: assert property ((st_ff.state == OSC_ST_RUN && !TX_PENDING && req_valid &&
    req != st_ff.cur && req != `OSC_MODE_SLEEP && !rst_evt) |=> OP_MODE == $past(req))
    else $error("requested mode not applied");
  invalid_req_a: assert property ((st_ff.state == OSC_ST_RUN && !req_valid && !rst_evt) |=>
    $stable(OP_MODE))
    else $error("invalid mode code acted on");
  sleep_drain_a: assert property (($rose(OSC_STOP) && !CLOCK_OUTPUT_PIN_OE_N) |->
    rise_ff >= 5'(DRAIN_PERIODS))
    else $error("too few clock out cycles before sleep");
  sleep_low_a: assert property ((st_ff.state == OSC_ST_SLEEP &&
    $past(st_ff.state) == OSC_ST_SLEEP) |-> !CLOCK_OUTPUT_PIN_O)
    else $error("clock out not low in sleep");
  clk_hiz_a: assert property (($fell(st_ff.ctrl.clock_output_enable) ##1 (!st_ff.ctrl.clock_output_enable)[*8]
    ##1 (!st_ff.ctrl.clock_output_enable)[*8]) |-> CLOCK_OUTPUT_PIN_OE_N)
    else $error("clock out still driven after disable");
  status_read_a: assert property ((REG_REQ.rd && REG_REQ.addr == `OSC_STAT_ADDR &&
    !CORE_RESET && !rst_evt) |=> REG_RDATA[7:5] == $past(OP_MODE))
    else $error("status mode field wrong");

  // Register port
  rdata_idle_a: assert property (!REG_REQ.rd |=> REG_RDATA == 8'h00)
    else $error("read data outside a read answer");

  stat_zero_a: assert property ((REG_REQ.rd && REG_REQ.addr == `OSC_STAT_ADDR) |=>
    (REG_RDATA[4] == 1'b0 && REG_RDATA[0] == 1'b0))
    else $error("status unused bits not zero");

  ctrl_read_a: assert property ((REG_REQ.rd && REG_REQ.addr == `OSC_CTRL_ADDR &&
    !CORE_RESET && !rst_evt) |=> REG_RDATA == $past(st_ff.ctrl))
    else $error("control read back wrong");

  ctrl_write_a: assert property ((REG_REQ.wr && REG_REQ.addr == `OSC_CTRL_ADDR &&
    !CORE_RESET && !rst_evt && !WAKE_EVENT) |=> st_ff.ctrl == $past(REG_REQ.wdata))
    else $error("control write not taken");

  write_drop_a: assert property ((REG_REQ.wr && REG_REQ.addr != `OSC_CTRL_ADDR &&
    !rst_evt && !WAKE_EVENT) |=> $stable(st_ff.ctrl))
    else $error("write to read-only address changed control");

  // Start-up and resets
  core_state_a: assert property (CORE_RESET == (st_ff.state == OSC_ST_STARTUP))
    else $error("core reset out of step with start-up");

  ost_range_a: assert property (st_ff.oscillator_startup_timer <= OST_LAST)
    else $error("start-up count past its end");

  ost_mode_a: assert property ((st_ff.state == OSC_ST_STARTUP && !rst_evt) |=>
    $stable(OP_MODE))
    else $error("mode changed during start-up");

  reset_quiet_a: assert property (rst_evt |=>
    (!OSC_STOP && REG_RDATA == 8'h00 && !ABORT_ALL && !ONE_SHOT))
    else $error("reset source left outputs active");

  pin_reset_a: assert property ((!RESET_PIN_N)[*2] |-> ##3 rst_evt)
    else $error("reset pin not seen in time");

  // Sleep and wake
  drain_enter_a: assert property ((st_ff.state == OSC_ST_RUN && !TX_PENDING &&
    req == `OSC_MODE_SLEEP && !rst_evt) |=> st_ff.state == OSC_ST_DRAIN)
    else $error("sleep request did not start drain");

  drain_count_a: assert property ((st_ff.state == OSC_ST_DRAIN) |->
    st_ff.drain <= DRAIN_LAST)
    else $error("drain count past its end");

  stop_state_a: assert property (OSC_STOP == (st_ff.state == OSC_ST_SLEEP))
    else $error("oscillator stop out of step with sleep");

  sleep_mode_a: assert property (OSC_STOP |-> OP_MODE == `OSC_MODE_SLEEP)
    else $error("stopped but mode is not sleep");

  sleep_hold_a: assert property ((st_ff.state == OSC_ST_SLEEP && !WAKE_EVENT &&
    !rst_evt) |=> st_ff.state == OSC_ST_SLEEP)
    else $error("sleep left without wake");

  sleep_pin_a: assert property (OSC_STOP |-> !CLOCK_OUTPUT_PIN_O)
    else $error("clock out high while stopped");

  hiz_low_a: assert property (CLOCK_OUTPUT_PIN_OE_N |-> !CLOCK_OUTPUT_PIN_O)
    else $error("clock out data high while released");

  wake_start_a: assert property ((st_ff.state == OSC_ST_SLEEP && WAKE_EVENT &&
    !rst_evt) |=> (CORE_RESET && !OSC_STOP && OP_MODE == `OSC_MODE_LISTEN))
    else $error("wake did not restart start-up");

  wake_req_a: assert property ((st_ff.state == OSC_ST_SLEEP && WAKE_EVENT &&
    !rst_evt) |=> st_ff.ctrl.req == `OSC_MODE_LISTEN)
    else $error("wake did not set listen request");

  sleep_enter_c: cover property ($rose(OSC_STOP));
  wake_c: cover property (st_ff.state == OSC_ST_SLEEP && WAKE_EVENT);
  normal_c: cover property ($changed(OP_MODE) && OP_MODE == `OSC_MODE_NORMAL);
  pin_reset_c: cover property ($fell(pin_rst_n));

endmodule : osc_startup_clock_output_pin_mode_ctrl

// ### tb/osc_clk_watch.sv
`timescale 1ns/10ps

module osc_clk_watch (
  input wire logic clk,
  input wire logic clr,
  input wire logic pin,
  output logic [7:0] min_hi,
  output logic [7:0] min_lo,
  output logic [7:0] rises
);
  logic [7:0] run;
  logic last;
  logic armed;
  wire lvl = (pin === 1'b1);

  // Host clock input: shortest whole phases and rising edges
  always @(posedge clk) begin
    if (clr) begin
      min_hi <= 8'hFF;
      min_lo <= 8'hFF;
      rises <= 8'h00;
      armed <= 1'b0;
      run <= 8'h01;
    end else if (lvl == last) begin
      run <= run + 8'h01;
    end else begin
      if (armed && last && run < min_hi) begin
        min_hi <= run;
      end
      if (armed && !last && run < min_lo) begin
        min_lo <= run;
      end
      if (lvl) begin
        rises <= rises + 8'h01;
      end
      armed <= 1'b1;
      run <= 8'h01;
    end
    last <= lvl;
  end

endmodule : osc_clk_watch

// ### tb/test_osc_startup_clock_output_pin_mode_ctrl.sv
`timescale 1ns/10ps
`include "osc_map.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, s); end end

module test_osc_startup_clock_output_pin_mode_ctrl;
  import osc_pkg::*;
  localparam int OSCILLATOR_STARTUP_TIMER = 8;
  localparam int DRN = 2;
  logic clk, rst, rst_pin_n, tx_pend, clr;
  logic [1:0] kick_v;
  logic [2:0] int_code, op_mode;
  osc_bus_req_s req;
  logic [7:0] rdata, rd_v, min_hi, min_lo, rises, h, ph;
  logic core_reset, osc_stop, abort_all, one_shot, ck_o, ck_oe_n;
  wire clk_pin = ck_oe_n ? 1'bz : ck_o;
  int num_errors = 0;
  int cmp_count = 0;
  int n;

  osc_startup_clock_output_pin_mode_ctrl #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER), .DRAIN_PERIODS(DRN)) u_dut (
    .CLK(clk), .RST(rst), .RESET_PIN_N(rst_pin_n), .SPI_RESET_CMD(kick_v[0]),
    .REG_REQ(req), .REG_RDATA(rdata), .TX_PENDING(tx_pend), .WAKE_EVENT(kick_v[1]),
    .INT_CODE(int_code), .CORE_RESET(core_reset), .OSC_STOP(osc_stop),
    .OP_MODE(op_mode), .ABORT_ALL(abort_all), .ONE_SHOT(one_shot),
    .CLOCK_OUTPUT_PIN_O(ck_o), .CLOCK_OUTPUT_PIN_OE_N(ck_oe_n)
  );

  osc_clk_watch u_watch (
    .clk(clk), .clr(clr), .pin(clk_pin), .min_hi(min_hi), .min_lo(min_lo), .rises(rises)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {a, d, 2'b10};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= {a, 8'h00, 2'b01};
    @(posedge clk);
    req <= '0;
    #1;
    rd_v = rdata;
  endtask : rd

  task automatic ost_len;
    n = 0;
    @(negedge clk);
    while (core_reset === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
  endtask : ost_len

  task automatic kick(input logic [1:0] k);
    @(posedge clk);
    kick_v <= k;
    @(posedge clk);
    kick_v <= 2'b00;
    ost_len();
  endtask : kick

  task automatic clr_p;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clr_p

  task automatic poll_mode(input logic [2:0] m);
    for (int i = 0; i < 20; i++) begin
      rd(`OSC_STAT_ADDR);
      if (rd_v[7:5] === m) break;
    end
  endtask : poll_mode

  task automatic results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b1;
    tx_pend = 1'b0;
    clr = 1'b1;
    kick_v = 2'b00;
    int_code = 3'h5;
    req = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    ost_len();
    `CHK("ost_por", OSCILLATOR_STARTUP_TIMER, n)
    `CHK("oe_n", 1'b0, ck_oe_n)
    rd(`OSC_CTRL_ADDR);
    `CHK("ctrl_rst", `OSC_CTRL_RST, rd_v)
    rd(`OSC_STAT_ADDR);
    `CHK("stat_rst", 8'h8A, rd_v)
    wr(`OSC_STAT_ADDR, 8'hFF);
    rd(`OSC_STAT_ADDR);
    `CHK("stat_ro", 8'h8A, rd_v)
    rd(8'h3C);
    `CHK("unmapped", 8'h00, rd_v)
    $display("test reset done");
    ph = 8'h08;
    foreach (h[i]) begin
      if (i < 4) begin
        clr_p();
        repeat (34) @(posedge clk);
        wr(`OSC_CTRL_ADDR, {6'b100001, 2'(3 - i)});
        repeat (40) @(posedge clk);
        h = 8'h01 << (3 - i);
        `CHK("min_chg", (h < ph) ? h : ph, min_hi)
        clr_p();
        repeat (40) @(posedge clk);
        `CHK("half_hi", h, min_hi)
        `CHK("half_lo", h, min_lo)
        ph = h;
      end
    end
    clr_p();
    wr(`OSC_CTRL_ADDR, 8'h80);
    repeat (20) @(posedge clk);
    `CHK("off", 1'b1, ck_oe_n)
    `CHK("off_lo", 1'b1, min_lo >= 8'h08)
    `CHK("off_hi", 1'b1, min_hi >= 8'h08)
    wr(`OSC_CTRL_ADDR, 8'h84);
    repeat (20) @(posedge clk);
    `CHK("on", 1'b0, ck_oe_n)
    $display("test clock_output_pin done");
    @(posedge clk) tx_pend <= 1'b1;
    wr(`OSC_CTRL_ADDR, 8'h44);
    repeat (8) @(posedge clk);
    rd(`OSC_STAT_ADDR);
    `CHK("defer", 3'h4, rd_v[7:5])
    @(posedge clk) tx_pend <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      h = (m == 0) ? 8'h02 : (m == 1) ? 8'h03 : (m == 2) ? 8'h00 : 8'h04;
      wr(`OSC_CTRL_ADDR, {h[2:0], 5'b00100});
      poll_mode(h[2:0]);
      `CHK("mode", h[2:0], rd_v[7:5])
      `CHK("op_mode", h[2:0], op_mode)
    end
    wr(`OSC_CTRL_ADDR, 8'hA4);
    repeat (8) @(posedge clk);
    `CHK("invalid", 3'h4, op_mode)
    wr(`OSC_CTRL_ADDR, 8'h9F);
    @(posedge clk);
    #1;
    `CHK("abort", 1'b1, abort_all)
    `CHK("oneshot", 1'b1, one_shot)
    $display("test modes done");
    @(posedge clk) tx_pend <= 1'b1;
    wr(`OSC_CTRL_ADDR, 8'h24);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tx_pend <= 1'b0;
    n = 0;
    while (osc_stop !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    `CHK("stop", 1'b1, osc_stop)
    `CHK("drain", 1'b1, rises >= DRN)
    `CHK("drain_max", 1'b1, rises <= DRN + 2)
    `CHK("sleep", 3'h1, op_mode)
    repeat (10) @(negedge clk);
    `CHK("idle_lo", 1'b0, ck_o)
    `CHK("idle_oe", 1'b0, ck_oe_n)
    kick(2'b10);
    `CHK("ost_wake", OSCILLATOR_STARTUP_TIMER, n)
    `CHK("wake_mode", 3'h3, op_mode)
    rd(`OSC_CTRL_ADDR);
    `CHK("wake_req", 3'h3, rd_v[7:5])
    $display("test sleep done");
    @(posedge clk) kick_v <= 2'b01;
    @(posedge clk) kick_v <= 2'b00;
    rd(`OSC_CTRL_ADDR);
    `CHK("ignored", 8'h00, rd_v)
    kick(2'b01);
    `CHK("ost_spi", OSCILLATOR_STARTUP_TIMER, n)
    rd(`OSC_CTRL_ADDR);
    `CHK("ctrl_spi", `OSC_CTRL_RST, rd_v)
    `CHK("abort_rst", 1'b0, abort_all)
    @(posedge clk) rst_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("pin_rst", 1'b1, core_reset)
    rst_pin_n <= 1'b1;
    ost_len();
    `CHK("pin_end", 1'b0, core_reset)
    rd(`OSC_CTRL_ADDR);
    `CHK("ctrl_pin", `OSC_CTRL_RST, rd_v)
    `CHK("mode_pin", 3'h4, op_mode)
    $display("test resets done");
    results();
  end

endmodule : test_osc_startup_clock_output_pin_mode_ctrl
